// file: host_command_pkg.sv
// constants, command codes and pin bundle for the host command data buffer
package host_command_pkg;

	localparam int HOST_DATA_W = 64;
	localparam int IPI_W = 8;
	localparam int GP_W = 32;
	localparam int FIFO_DEPTH = 4;

	localparam logic [IPI_W-1:0] IPI_RESET = 8'h00;
	localparam logic [GP_W-1:0] GP_RESET = 32'h00000000;
	localparam int PARITY_EN_BIT = 31;
	localparam int DRAM_ORG_BIT = 30;

	typedef enum logic [3:0] {
		CMD_IDLE = 4'h0,
		CMD_PUSH_MEM = 4'h1,
		CMD_PUSH_PCI_HD = 4'h2,
		CMD_PUSH_PCI_MD = 4'h3,
		CMD_INIT_PCI_REAR = 4'h4,
		CMD_WR_IPI = 4'h5,
		CMD_WR_GP = 4'h6,
		CMD_POP_IDE = 4'h7,
		CMD_DRV_LATCH = 4'h8,
		CMD_RD_IPI = 4'h9,
		CMD_RD_GP = 4'ha,
		CMD_RESERVED = 4'hb,
		CMD_DRV_PCI = 4'hc,
		CMD_DRV_PCI_POP = 4'hd,
		CMD_DRV_MST = 4'he,
		CMD_DRV_MST_POP = 4'hf
	} cmd_e;

	typedef struct packed {
		cmd_e cmd;
		logic [HOST_DATA_W-1:0] hd;
		logic [HOST_DATA_W-1:0] md;
	} pin_in_s;

endpackage

// file: pin_sync.sv
// two-flop synchroniser for pin inputs
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;

	// first stage is read only by the second
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// file: fifo_store.sv
// circular fifo storage with one write port and a registered read port
module fifo_store #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 4,
	parameter int PTR_W = $clog2(DEPTH)
) (
	input wire logic ref_clk,
	input wire logic wrEn,
	input wire logic [PTR_W-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [PTR_W-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge ref_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge ref_clk) begin
		rdData <= mem[rdAddr];
	end
endmodule

// file: host_command_data_buffer.sv
// host command decoder and fifo pointers of the data buffer
//
// How it works
// [R1] each fifo pushes at rear, pops at front
// [R2] idle code leaves host bus undriven
// [R3] 0001 pushes host word into memory fifo
// [R4] 0010 pushes host word into pci fifo
// [R5] 0011 pushes memory word into pci fifo
// [R6] 0100 returns pci fifo rear to start
// [R7] controller flushes prefetch after master reads
// [R8] 0101 loads vector register from host bus
// [R9] 0110 writes general purpose register
// [R10] bit 31 enables parity, resets zero
// [R11] software keeps parity off for 32-bit
// [R12] other general bits hold written value
// [R13] 0111 advances ide prefetch read pointer
// [R14] 1000 drives dram read latch out
// [R15] 1100 drives pci-to-host fifo data out
// [R16] 1101 advances pci-to-host front pointer
// [R17] 1110 drives pci-to-host front entry out
// [R18] 1111 pops once while still driving
// [R19] 1001 drives vector register out
// [R20] 1010 drives general register out
// [R21] bit 30 selects dram width, resets zero
// [R22] reserved 1011 behaves as idle
// [R23] drivers enabled only for drive codes
module host_command_data_buffer
	import host_command_pkg::*;
#(
	parameter int DEPTH = host_command_pkg::FIFO_DEPTH,
	parameter int WIDTH = host_command_pkg::HOST_DATA_W
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [3:0] hostCommandCode,
	input wire logic [host_command_pkg::HOST_DATA_W-1:0] hostDataIn,
	output logic [host_command_pkg::HOST_DATA_W-1:0] hostDataOut_r,
	output logic hostDataOe_r,
	input wire logic [host_command_pkg::HOST_DATA_W-1:0] memoryDataIn,
	input wire logic dramLatchLoad,
	input wire logic cpuToMemPop,
	output logic [host_command_pkg::HOST_DATA_W-1:0] cpuToMemData,
	input wire logic cpuToPciPop,
	output logic [host_command_pkg::HOST_DATA_W-1:0] cpuToPciData,
	input wire logic pciToHostPush,
	input wire logic [host_command_pkg::HOST_DATA_W-1:0] pciToHostWrData,
	output logic [host_command_pkg::IPI_W-1:0] ipiVector_r,
	output logic [host_command_pkg::GP_W-1:0] generalPurpose_r
);
	import host_command_pkg::*;

	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
	localparam logic [PTR_W-1:0] PTR_FIRST = '0;

	function automatic logic isDrive(input cmd_e c);
		case (c)
			CMD_DRV_LATCH, CMD_RD_IPI, CMD_RD_GP, CMD_DRV_PCI,
			CMD_DRV_PCI_POP, CMD_DRV_MST, CMD_DRV_MST_POP: isDrive = 1'b1;
			default: isDrive = 1'b0;
		endcase
	endfunction

	pin_in_s pinIn;
	pin_in_s syncIn;
	logic [PTR_W-1:0] ctmRear_r, ctmFront_r;
	logic [PTR_W-1:0] ctpRear_r, ctpFront_r;
	logic [PTR_W-1:0] pthRear_r, pthFront_r;
	logic [WIDTH-1:0] dramReadLatch_r;
	logic [WIDTH-1:0] pthData;
	logic [WIDTH-1:0] ctpWrData;
	logic [WIDTH-1:0] driveData;
	logic ctmPush, ctpPush, pthPop;

	////////////////////////////////////////////////////////////////////////////////
	// pins: code and both data buses cross together so they stay aligned

	assign pinIn = '{cmd: cmd_e'(hostCommandCode), hd: hostDataIn, md: memoryDataIn};

	pin_sync #(.WIDTH($bits(pin_in_s))) pinSync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.d(pinIn),
		.q(syncIn)
	);

	////////////////////////////////////////////////////////////////////////////////
	// fifo storage

	assign ctmPush = (syncIn.cmd == CMD_PUSH_MEM);
	assign ctpPush = (syncIn.cmd == CMD_PUSH_PCI_HD) || (syncIn.cmd == CMD_PUSH_PCI_MD);
	// both pop codes and the ide pop walk the same front pointer
	assign pthPop = (syncIn.cmd == CMD_POP_IDE) || (syncIn.cmd == CMD_DRV_PCI_POP) ||
		(syncIn.cmd == CMD_DRV_MST_POP);
	assign ctpWrData = (syncIn.cmd == CMD_PUSH_PCI_MD) ? syncIn.md : syncIn.hd;

	// [R1] rear writes, front reads
	fifo_store #(.WIDTH(WIDTH), .DEPTH(DEPTH)) cpuToMemFifo (
		.ref_clk(ref_clk),
		.wrEn(ctmPush),
		.wrAddr(ctmRear_r),
		.wrData(syncIn.hd),
		.rdAddr(ctmFront_r),
		.rdData(cpuToMemData)
	);

	fifo_store #(.WIDTH(WIDTH), .DEPTH(DEPTH)) cpuToPciFifo (
		.ref_clk(ref_clk),
		.wrEn(ctpPush),
		.wrAddr(ctpRear_r),
		.wrData(ctpWrData),
		.rdAddr(ctpFront_r),
		.rdData(cpuToPciData)
	);

	fifo_store #(.WIDTH(WIDTH), .DEPTH(DEPTH)) pciToHostFifo (
		.ref_clk(ref_clk),
		.wrEn(pciToHostPush),
		.wrAddr(pthRear_r),
		.wrData(pciToHostWrData),
		.rdAddr(pthFront_r),
		.rdData(pthData)
	);

	////////////////////////////////////////////////////////////////////////////////
	// pointers; no full or empty guard, the controller tracks occupancy
	// and depth must be a power of two for the wrap to be natural

	// [R3] memory fifo push
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ctmRear_r <= PTR_FIRST;
			ctmFront_r <= PTR_FIRST;
		end else begin
			if (ctmPush) begin
				ctmRear_r <= ctmRear_r + PTR_ONE;
			end
			if (cpuToMemPop) begin
				ctmFront_r <= ctmFront_r + PTR_ONE;
			end
		end
	end

	// [R4] [R5] [R6] pci fifo push and rear initialise
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ctpRear_r <= PTR_FIRST;
			ctpFront_r <= PTR_FIRST;
		end else begin
			if (syncIn.cmd == CMD_INIT_PCI_REAR) begin
				ctpRear_r <= PTR_FIRST;
			end else if (ctpPush) begin
				ctpRear_r <= ctpRear_r + PTR_ONE;
			end
			if (cpuToPciPop) begin
				ctpFront_r <= ctpFront_r + PTR_ONE;
			end
		end
	end

	// [R13] [R16] [R18] pci-to-host front advance
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pthRear_r <= PTR_FIRST;
			pthFront_r <= PTR_FIRST;
		end else begin
			if (pciToHostPush) begin
				pthRear_r <= pthRear_r + PTR_ONE;
			end
			if (pthPop) begin
				pthFront_r <= pthFront_r + PTR_ONE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	// [R8] vector load
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ipiVector_r <= IPI_RESET;
		end else if (syncIn.cmd == CMD_WR_IPI) begin
			ipiVector_r <= syncIn.hd[IPI_W-1:0];
		end
	end

	// [R9] [R10] [R12] [R21] whole word written; bits 31 and 30 reset clear
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			generalPurpose_r <= GP_RESET;
		end else if (syncIn.cmd == CMD_WR_GP) begin
			generalPurpose_r <= syncIn.hd[GP_W-1:0];
		end
	end

	// latch captures the memory bus as seen after synchronising
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			dramReadLatch_r <= '0;
		end else if (dramLatchLoad) begin
			dramReadLatch_r <= syncIn.md;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// host bus drive; registered, so data appear one edge after the synchronised code

	// [R14] [R15] [R17] [R19] [R20] drive source select
	always_comb begin
		case (syncIn.cmd)
			CMD_DRV_LATCH: driveData = dramReadLatch_r;
			CMD_DRV_PCI, CMD_DRV_PCI_POP, CMD_DRV_MST, CMD_DRV_MST_POP: driveData = pthData;
			CMD_RD_IPI: driveData = WIDTH'(ipiVector_r);
			CMD_RD_GP: driveData = WIDTH'(generalPurpose_r);
			default: driveData = '0;
		endcase
	end

	// [R2] [R22] [R23] enable only for drive codes
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			hostDataOe_r <= 1'b0;
			hostDataOut_r <= '0;
		end else begin
			hostDataOe_r <= isDrive(syncIn.cmd);
			hostDataOut_r <= driveData;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	sequence popDriveSeq;
		syncIn.cmd == CMD_DRV_MST_POP;
	endsequence

	sequence frontStepSeq;
		hostDataOe_r && (pthFront_r == $past(pthFront_r) + PTR_ONE);
	endsequence

	idle_release_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R2]
		syncIn.cmd == CMD_IDLE |=> !hostDataOe_r)
		else $error("host bus driven during idle");

	mem_push_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R3]
		ctmPush |=> ctmRear_r == $past(ctmRear_r) + PTR_ONE)
		else $error("memory fifo rear did not advance");

	pci_push_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R4]
		ctpPush |=> ctpRear_r == $past(ctpRear_r) + PTR_ONE)
		else $error("pci fifo rear did not advance");

	prefetch_source_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R5]
		syncIn.cmd == CMD_PUSH_PCI_MD |-> ctpWrData == syncIn.md)
		else $error("prefetch push not from memory bus");

	rear_init_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R6]
		syncIn.cmd == CMD_INIT_PCI_REAR |=> ctpRear_r == PTR_FIRST)
		else $error("pci fifo rear not initialised");

	vector_load_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R8]
		syncIn.cmd == CMD_WR_IPI |=> ipiVector_r == $past(syncIn.hd[IPI_W-1:0]))
		else $error("vector register not loaded");

	gp_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R9]
		syncIn.cmd == CMD_WR_GP |=> generalPurpose_r == $past(syncIn.hd[GP_W-1:0]))
		else $error("general register not written");

	gp_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R12]
		syncIn.cmd != CMD_WR_GP |=> $stable(generalPurpose_r))
		else $error("general register changed without write");

	ctrl_reset_a: assert property (@(posedge ref_clk) // [R10]
		!rst_b |=> !generalPurpose_r[PARITY_EN_BIT] && !generalPurpose_r[DRAM_ORG_BIT])
		else $error("control bits not clear after reset");

	ide_pop_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R13]
		syncIn.cmd == CMD_POP_IDE |=> pthFront_r == $past(pthFront_r) + PTR_ONE)
		else $error("ide pop did not advance front");

	latch_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R14]
		syncIn.cmd == CMD_DRV_LATCH |=> hostDataOe_r && hostDataOut_r == $past(dramReadLatch_r))
		else $error("dram latch not driven");

	pci_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R15]
		syncIn.cmd == CMD_DRV_PCI |=> hostDataOe_r && hostDataOut_r == $past(pthData))
		else $error("pci fifo data not driven");

	fifo_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R17]
		syncIn.cmd == CMD_DRV_MST |=> hostDataOut_r == $past(pthData) && hostDataOe_r)
		else $error("front entry not driven");

	burst_pop_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R16]
		syncIn.cmd == CMD_DRV_PCI_POP |=> frontStepSeq)
		else $error("burst pop did not advance or drive");

	pop_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R18]
		popDriveSeq |=> frontStepSeq)
		else $error("pop code lost drive or front step");

	vector_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R19]
		syncIn.cmd == CMD_RD_IPI |=> hostDataOut_r == WIDTH'($past(ipiVector_r)))
		else $error("vector register not driven");

	gp_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R20]
		syncIn.cmd == CMD_RD_GP |=> hostDataOut_r == WIDTH'($past(generalPurpose_r)))
		else $error("general register not driven");

	reserved_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R22]
		syncIn.cmd == CMD_RESERVED |=> !hostDataOe_r && $stable(ctpRear_r) && $stable(ipiVector_r))
		else $error("reserved code had an effect");

	drive_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R23]
		!isDrive(syncIn.cmd) |=> !hostDataOe_r)
		else $error("host bus driven for non-drive code");

endmodule

// file: host_controller_model.sv
// behavioural system controller issuing host command codes and bus words
module host_controller_model
	import host_command_pkg::*;
(
	input wire logic ref_clk,
	output logic [3:0] hostCommandCode,
	output logic [host_command_pkg::HOST_DATA_W-1:0] hostDataIn,
	output logic [host_command_pkg::HOST_DATA_W-1:0] memoryDataIn,
	input wire logic [host_command_pkg::HOST_DATA_W-1:0] hostDataOut_r,
	input wire logic hostDataOe_r
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [HOST_DATA_W-1:0] hdDrive = '0;
	logic [HOST_DATA_W-1:0] hdLast = '0;
	logic hdEn = 1'b0;
	// a released bus shows the inverse of the last word, never a stale copy
	assign hostDataIn = hostDataOe_r ? hostDataOut_r : (hdEn ? hdDrive : ~hdLast);
	initial begin
		hostCommandCode = CMD_IDLE;
		memoryDataIn = '0;
	end
	// one code per clock
	// called at a falling edge; every call holds its code for exactly one clock
	task automatic issue(input cmd_e code, input logic [HOST_DATA_W-1:0] hd,
		input logic [HOST_DATA_W-1:0] md);
		hostCommandCode = code;
		hdEn = code inside {CMD_PUSH_MEM, CMD_PUSH_PCI_HD, CMD_WR_IPI, CMD_WR_GP};
		hdDrive = hd;
		if (hdEn)
			hdLast = hd;
		memoryDataIn = md;
		@(negedge ref_clk);
	endtask
endmodule

// file: host_command_data_buffer_test.sv
// self-checking bench for the host command data buffer
module host_command_data_buffer_test
	import host_command_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		cmd_e wr;
		logic [63:0] hd;
		logic [63:0] md;
		cmd_e rd;
		logic [63:0] exp;
	} row_s;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic dramLatchLoad = 1'b0;
	logic cpuToMemPop = 1'b0;
	logic cpuToPciPop = 1'b0;
	logic pciToHostPush = 1'b0;
	logic [63:0] pciToHostWrData = '0;
	logic [3:0] hostCommandCode;
	logic [63:0] hostDataIn, memoryDataIn, hostDataOut_r, cpuToMemData, cpuToPciData;
	logic hostDataOe_r;
	logic [7:0] ipiVector_r;
	logic [31:0] generalPurpose_r;
	int badCount = 0;
	int nTests = 0;
	row_s rows[5] = '{
		'{CMD_WR_IPI, 64'hffff_ffff_ffff_ffa5, 64'h0, CMD_RD_IPI, 64'ha5},
		'{CMD_WR_GP, 64'hffff_ffff_8000_0000, 64'h0, CMD_RD_GP, 64'h8000_0000},
		'{CMD_WR_GP, 64'h1234_5678_4bad_cafe, 64'h0, CMD_RD_GP, 64'h4bad_cafe},
		'{CMD_IDLE, 64'h0, 64'h0123_4567_89ab_cdef, CMD_DRV_LATCH, 64'h0123_4567_89ab_cdef},
		'{CMD_WR_IPI, 64'h5a, 64'hfedc_ba98_7654_3210, CMD_DRV_LATCH, 64'hfedc_ba98_7654_3210}
	};

	always #2.5 ref_clk = ~ref_clk;

	host_command_data_buffer dut (.ref_clk, .rst_b, .hostCommandCode, .hostDataIn,
		.hostDataOut_r, .hostDataOe_r, .memoryDataIn, .dramLatchLoad, .cpuToMemPop,
		.cpuToMemData, .cpuToPciPop, .cpuToPciData, .pciToHostPush, .pciToHostWrData,
		.ipiVector_r, .generalPurpose_r);
	host_controller_model ctl (.ref_clk, .hostCommandCode, .hostDataIn, .memoryDataIn,
		.hostDataOut_r, .hostDataOe_r);

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
		nTests++;
		if (got !== exp) begin
			badCount++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	function automatic logic [63:0] word(input logic [31:0] base, input int i);
		return {base, 32'(i)};
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// watchdog: the whole sequence needs well under a thousand clocks
	initial begin
		#50000;
		badCount++;
		conclude();
	end

	////////////////////////////////////////////////////////////////
	initial begin
		// two edges: each one clears both synchroniser stages
		cyc(2);
		check(64'(ipiVector_r), 64'h0, "vector reset");
		check(64'(generalPurpose_r), 64'h0, "general reset");
		check({63'h0, hostDataOe_r}, 64'h0, "bus released in reset");
		rst_b = 1'b1;
		cyc(1);
		foreach (rows[i]) begin
			ctl.issue(rows[i].wr, rows[i].hd, rows[i].md);
			repeat (2) ctl.issue(CMD_IDLE, '0, rows[i].md);
			dramLatchLoad = 1'b1;
			ctl.issue(CMD_IDLE, '0, rows[i].md);
			dramLatchLoad = 1'b0;
			repeat (4) ctl.issue(rows[i].rd, '0, rows[i].md);
			check(hostDataOut_r, rows[i].exp, "readback");
			check({63'h0, hostDataOe_r}, 64'h1, "bus driven");
			repeat (4) ctl.issue(CMD_IDLE, '0, '0);
			check({63'h0, hostDataOe_r}, 64'h0, "bus released");
		end
		repeat (4) ctl.issue(CMD_RESERVED, 64'h1, 64'h1);
		check({63'h0, hostDataOe_r}, 64'h0, "reserved undriven");
		repeat (3) ctl.issue(CMD_IDLE, '0, '0);
		check(64'(ipiVector_r), 64'h5a, "vector kept");
		check(64'(generalPurpose_r), 64'h4bad_cafe, "general kept");
		for (int i = 0; i < 3; i++)
			ctl.issue(CMD_PUSH_MEM, word(32'h3e3e_0000, i), '0);
		repeat (3) ctl.issue(CMD_IDLE, '0, '0);
		for (int i = 0; i < 3; i++) begin
			check(cpuToMemData, word(32'h3e3e_0000, i), "memory fifo order");
			cpuToMemPop = 1'b1;
			cyc(1);
			cpuToMemPop = 1'b0;
			cyc(2);
		end
		ctl.issue(CMD_PUSH_PCI_HD, 64'ha1, '0);
		ctl.issue(CMD_PUSH_PCI_MD, '0, 64'hb2);
		ctl.issue(CMD_INIT_PCI_REAR, '0, '0);
		ctl.issue(CMD_PUSH_PCI_HD, 64'hc3, '0);
		repeat (3) ctl.issue(CMD_IDLE, '0, '0);
		check(cpuToPciData, 64'hc3, "rear restarted");
		cpuToPciPop = 1'b1;
		cyc(1);
		cpuToPciPop = 1'b0;
		cyc(2);
		check(cpuToPciData, 64'hb2, "memory word kept");
		// the ide pop is only legal while prefetch data is held, so fill first
		pciToHostPush = 1'b1;
		for (int i = 0; i < 4; i++) begin
			pciToHostWrData = word(32'h7e57_0000, i);
			cyc(1);
		end
		pciToHostPush = 1'b0;
		ctl.issue(CMD_POP_IDE, 64'h2, '0);
		repeat (5) ctl.issue(CMD_DRV_PCI, '0, '0);
		check(hostDataOut_r, word(32'h7e57_0000, 1), "pci front driven");
		for (int i = 0; i < 14; i++) begin
			ctl.issue(i == 0 ? CMD_DRV_PCI_POP : i == 7 ? CMD_DRV_MST_POP : CMD_DRV_MST, '0, '0);
			check({63'h0, hostDataOe_r}, 64'h1, "bus held");
			if (i == 6)
				check(hostDataOut_r, word(32'h7e57_0000, 2), "one pop");
		end
		check(hostDataOut_r, word(32'h7e57_0000, 3), "two pops");
		ctl.issue(CMD_IDLE, '0, '0);
		rst_b = 1'b0;
		cyc(3);
		check(64'(ipiVector_r), 64'h0, "vector reset again");
		check(64'(generalPurpose_r), 64'h0, "general reset again");
		check({63'h0, hostDataOe_r}, 64'h0, "bus released in reset again");
		rst_b = 1'b1;
		cyc(2);
		conclude();
	end
endmodule
